// file: rtl/mpgpi_defines.svh
// Constants for the position-detection input control block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef MPGPI_DEFINES_SVH
`define MPGPI_DEFINES_SVH

// ==========================================================================
// Register addresses
`define MPGPI_ADDR_UPPER 4'h0
`define MPGPI_ADDR_LOWER 4'h1
`define MPGPI_ADDR_IRQ_STAT 4'h2
`define MPGPI_ADDR_IRQ_MASK 4'h3
`define MPGPI_ADDR_FILT_LEN 4'h4
`define MPGPI_ADDR_STATUS 4'h5

// ==========================================================================
// Field positions, upper register
`define MPGPI_UP_WTS_HI 7
`define MPGPI_UP_WTS_LO 6
`define MPGPI_UP_FLAG 5
`define MPGPI_UP_IEN 4
`define MPGPI_UP_CMP_HI 3
`define MPGPI_UP_CMP_LO 1
`define MPGPI_UP_CMPEN 0

// ==========================================================================
// Field positions, lower register
`define MPGPI_LO_POL_HI 7
`define MPGPI_LO_POL_LO 6
`define MPGPI_LO_FLT_HI 5
`define MPGPI_LO_FLT_LO 3
`define MPGPI_LO_SEE_HI 2
`define MPGPI_LO_SEE_LO 0

// ==========================================================================
// Event bits of the status and mask registers
`define MPGPI_EV_CMP 0
`define MPGPI_EV_SENSOR 1
`define MPGPI_EV_WSYNC 2
`define MPGPI_EV_W 3

// ==========================================================================
// Reset values
`define MPGPI_RST_CTRL 8'h00
`define MPGPI_RST_FLEN 2'h0

`endif

// file: rtl/mpgpi_pkg.sv
// Types shared by the position-detection input control files.
// Assumes the defines header is on the include path.
`include "mpgpi_defines.svh"

package mpgpi_pkg;

    // ======================================================================
    // Edge selection codes, used by write sync and sensor polarity
    typedef enum logic [1:0] {
        MPGPI_EDGE_NONE = 2'b00,
        MPGPI_EDGE_RISE = 2'b01,
        MPGPI_EDGE_FALL = 2'b10,
        MPGPI_EDGE_BOTH = 2'b11
    } mpgpi_edge_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic rmw;
    } mpgpi_req_t;

    // Output bank position from the output control logic
    typedef struct packed {
        logic bank_flag;
        logic [2:0] index;
    } mpgpi_bank_t;

endpackage : mpgpi_pkg

// file: rtl/mpgpi_filter.sv
// One sensor input noise canceller.
// Assumes a synchronised input on the same clock as the filter.
`timescale 1ns/1ps

module mpgpi_filter #(
    parameter int MAX_BITS = 5
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Control
    input wire logic clk_run_i,
    input wire logic [1:0] len_sel_i,
    // Data
    input wire logic raw_i,
    output logic clean_o
);
    logic [MAX_BITS-1:0] cnt_reg;
    logic clean_reg;
    logic [MAX_BITS-1:0] limit;
    logic differs;

    // Counter length n = 2 + len_sel, overflow at 2^n - 1
    assign limit = MAX_BITS'((1 << (32'(len_sel_i) + 2)) - 1);
    assign differs = raw_i != clean_reg;
    assign clean_o = clean_reg;

    // Accept a new level only once it has held until overflow
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg <= '0;
            clean_reg <= 1'b0;
        end else if (!clk_run_i) begin
            cnt_reg <= '0; // Filtered input invalid while stopped
            clean_reg <= 1'b0;
        end else if (!differs) begin
            cnt_reg <= '0; // Short pulse rejected
        end else if (cnt_reg == limit) begin
            cnt_reg <= '0;
            clean_reg <= raw_i;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule : mpgpi_filter

// file: rtl/mpgpi_top.sv
// Position-detection input control: two control registers, compare
// of the output bank index, write sync edge detect, sensor filtering
// and edge detection for three sensor inputs.
// Assumes a single clock; sensor and pulse-gen pins are asynchronous,
// the bank index comes from logic on the same clock.
//
// Functional notes
// - Write sync field picks none, rising, falling or both pulse-gen edges.
// - Flag sets when bank index changes to the compare value, or on enabling compare at a match.
// - Compare interrupt is high only while enable and flag are both one.
// - Writing zero clears the flag; writing one changes nothing.
// - Read-modify-write reads return one in the flag bit.
// - Three-bit compare value in bits 3:1, every code can match.
// - Upper bit 0 enables the position compare operation.
// - Polarity field selects stop, rising, falling or both sensor edges.
// - Filter enable bits 5:3 route sensors 2:0 through their cancellers.
// - Canceller accepts a level only after an n-bit counter overflows, n 2..5.
// - Filtered input is invalid while the internal clock is stopped.
// - Bits 2 and 1 enable edge detection on sensors 2 and 1.
// - Lower bit 0 enables edge detection on sensor 0.
// - Bank index with bank flag selects the next buffer; compare watches it.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "mpgpi_defines.svh"

module mpgpi_top #(
    parameter int SENSORS = 3,
    parameter int FILT_MAX_BITS = 5
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Register port
    input wire mpgpi_pkg::mpgpi_req_t req_i,
    output logic [7:0] rdata_o,
    // Output bank position and clock state
    input wire mpgpi_pkg::mpgpi_bank_t bank_i,
    input wire logic clk_run_i,
    // Pins
    input wire logic pulse_gen_signal_i,
    input wire logic [SENSORS-1:0] sensor_in_i,
    // Events and interrupts
    output logic write_sync_o,
    output logic posdet_o,
    output logic cmp_irq_o,
    output logic irq_o
);
    import mpgpi_pkg::*;

    // ======================================================================
    // Registers
    logic [7:0] upper_reg;
    logic [7:0] upper_next;
    logic [7:0] lower_reg;
    logic [`MPGPI_EV_W-1:0] stat_reg;
    logic [`MPGPI_EV_W-1:0] stat_next;
    logic [`MPGPI_EV_W-1:0] mask_reg;
    logic [1:0] flen_reg;
    logic [7:0] rdata_reg;
    logic write_sync_reg;
    logic posdet_reg;
    logic cmp_irq_reg;
    logic irq_reg;
    logic [2:0] idx_prev_reg;
    logic cmp_en_prev_reg;

    // ======================================================================
    // Register decode
    wire wr_upper = req_i.wr && (req_i.addr == `MPGPI_ADDR_UPPER);
    wire wr_lower = req_i.wr && (req_i.addr == `MPGPI_ADDR_LOWER);
    wire wr_stat = req_i.wr && (req_i.addr == `MPGPI_ADDR_IRQ_STAT);
    wire wr_mask = req_i.wr && (req_i.addr == `MPGPI_ADDR_IRQ_MASK);
    wire wr_flen = req_i.wr && (req_i.addr == `MPGPI_ADDR_FILT_LEN);

    // Control fields
    wire mpgpi_edge_t wsync_sel = mpgpi_edge_t'(upper_reg[`MPGPI_UP_WTS_HI:`MPGPI_UP_WTS_LO]);
    wire cmp_flag = upper_reg[`MPGPI_UP_FLAG];
    wire cmp_ien = upper_reg[`MPGPI_UP_IEN];
    wire [2:0] cmp_value = upper_reg[`MPGPI_UP_CMP_HI:`MPGPI_UP_CMP_LO];
    wire posdet_cmp_en = upper_reg[`MPGPI_UP_CMPEN];
    wire mpgpi_edge_t pol_sel = mpgpi_edge_t'(lower_reg[`MPGPI_LO_POL_HI:`MPGPI_LO_POL_LO]);
    wire [SENSORS-1:0] filt_en = lower_reg[`MPGPI_LO_FLT_HI:`MPGPI_LO_FLT_LO];
    wire [SENSORS-1:0] edge_en = lower_reg[`MPGPI_LO_SEE_HI:`MPGPI_LO_SEE_LO];

    // ======================================================================
    // Pin synchronisers
    logic pg_meta_reg;
    logic pg_sync_reg;
    logic pg_prev_reg;
    logic [SENSORS-1:0] sn_meta_reg;
    logic [SENSORS-1:0] sn_sync_reg;
    logic [SENSORS-1:0] sn_prev_reg;
    logic [SENSORS-1:0] sn_filt;
    logic [SENSORS-1:0] sn_sel;

    // Two-stage synchronisers for all asynchronous pins
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pg_meta_reg <= 1'b0;
            pg_sync_reg <= 1'b0;
            sn_meta_reg <= '0;
            sn_sync_reg <= '0;
        end else begin
            pg_meta_reg <= pulse_gen_signal_i;
            pg_sync_reg <= pg_meta_reg;
            sn_meta_reg <= sensor_in_i;
            sn_sync_reg <= sn_meta_reg;
        end
    end

    // ======================================================================
    // Noise cancellers, one per sensor
    genvar gi;
    generate
        for (gi = 0; gi < SENSORS; gi++) begin : g_filt
            mpgpi_filter #(
                .MAX_BITS(FILT_MAX_BITS)
            ) u_filt (
                .ref_clk_i(ref_clk_i),
                .reset_i(reset_i),
                .clk_run_i(clk_run_i),
                .len_sel_i(flen_reg),
                .raw_i(sn_sync_reg[gi]),
                .clean_o(sn_filt[gi])
            );
        end
    endgenerate

    // Filter route or bypass per sensor
    assign sn_sel = (filt_en & sn_filt) | (~filt_en & sn_sync_reg);

    // ======================================================================
    // Edge detection
    wire pg_rise = pg_sync_reg && !pg_prev_reg;
    wire pg_fall = !pg_sync_reg && pg_prev_reg;
    wire [SENSORS-1:0] sn_rise = sn_sel & ~sn_prev_reg;
    wire [SENSORS-1:0] sn_fall = ~sn_sel & sn_prev_reg;

    // Write sync edge select
    logic wsync_hit;
    always_comb begin
        case (wsync_sel)
            MPGPI_EDGE_NONE: wsync_hit = 1'b0;
            MPGPI_EDGE_RISE: wsync_hit = pg_rise;
            MPGPI_EDGE_FALL: wsync_hit = pg_fall;
            MPGPI_EDGE_BOTH: wsync_hit = pg_rise || pg_fall;
            default: wsync_hit = 1'b0;
        endcase
    end

    // Sensor polarity select, gated by per-sensor edge enables
    logic [SENSORS-1:0] sn_hit_raw;
    always_comb begin
        case (pol_sel)
            MPGPI_EDGE_NONE: sn_hit_raw = '0;
            MPGPI_EDGE_RISE: sn_hit_raw = sn_rise;
            MPGPI_EDGE_FALL: sn_hit_raw = sn_fall;
            MPGPI_EDGE_BOTH: sn_hit_raw = sn_rise | sn_fall;
            default: sn_hit_raw = '0;
        endcase
    end
    wire sn_hit = |(sn_hit_raw & edge_en);

    // ======================================================================
    // Compare of output bank index
    wire idx_match = bank_i.index == cmp_value;
    // Fire on entering a match, or on enabling compare while matching
    wire idx_event = (bank_i.index != idx_prev_reg) || !cmp_en_prev_reg;
    wire cmp_set = posdet_cmp_en && idx_match && idx_event;

    // Next upper register: flag set wins over a clearing write
    always_comb begin
        upper_next = upper_reg;
        if (wr_upper) begin
            upper_next = req_i.wdata;
            // Writing one keeps the flag, zero clears it
            upper_next[`MPGPI_UP_FLAG] = cmp_flag && req_i.wdata[`MPGPI_UP_FLAG];
        end
        if (cmp_set) begin
            upper_next[`MPGPI_UP_FLAG] = 1'b1;
        end
    end

    // Sticky event status, write one to clear, set wins
    wire [`MPGPI_EV_W-1:0] ev_set = {wsync_hit, sn_hit, cmp_set};
    assign stat_next = (stat_reg & ~(wr_stat ? req_i.wdata[`MPGPI_EV_W-1:0] : '0)) | ev_set;

    // ======================================================================
    // Read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (req_i.addr)
            `MPGPI_ADDR_UPPER: begin
                rd_mux = upper_reg;
                if (req_i.rmw) begin
                    rd_mux[`MPGPI_UP_FLAG] = 1'b1;
                end
            end
            `MPGPI_ADDR_LOWER: rd_mux = lower_reg;
            `MPGPI_ADDR_IRQ_STAT: rd_mux = {5'h00, stat_reg};
            `MPGPI_ADDR_IRQ_MASK: rd_mux = {5'h00, mask_reg};
            `MPGPI_ADDR_FILT_LEN: rd_mux = {6'h00, flen_reg};
            `MPGPI_ADDR_STATUS: rd_mux = {4'h0, bank_i.bank_flag, sn_sel};
            default: rd_mux = 8'h00;
        endcase
    end

    // ======================================================================
    // Control registers, reset to zero
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            upper_reg <= `MPGPI_RST_CTRL;
            lower_reg <= `MPGPI_RST_CTRL;
            mask_reg <= '0;
            flen_reg <= `MPGPI_RST_FLEN;
            stat_reg <= '0;
        end else begin
            upper_reg <= upper_next;
            if (wr_lower) begin
                lower_reg <= req_i.wdata;
            end
            if (wr_mask) begin
                mask_reg <= req_i.wdata[`MPGPI_EV_W-1:0];
            end
            if (wr_flen) begin
                flen_reg <= req_i.wdata[1:0];
            end
            stat_reg <= stat_next;
        end
    end

    // Edge history and compare history
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pg_prev_reg <= 1'b0;
            sn_prev_reg <= '0;
            idx_prev_reg <= 3'h0;
            cmp_en_prev_reg <= 1'b0;
        end else begin
            pg_prev_reg <= pg_sync_reg;
            sn_prev_reg <= sn_sel;
            idx_prev_reg <= bank_i.index;
            cmp_en_prev_reg <= posdet_cmp_en;
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_reg <= 8'h00;
            write_sync_reg <= 1'b0;
            posdet_reg <= 1'b0;
            cmp_irq_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            rdata_reg <= req_i.rd ? rd_mux : 8'h00;
            write_sync_reg <= wsync_hit;
            posdet_reg <= sn_hit;
            cmp_irq_reg <= upper_next[`MPGPI_UP_IEN] && upper_next[`MPGPI_UP_FLAG];
            irq_reg <= |(stat_next & mask_reg);
        end
    end

    assign rdata_o = rdata_reg;
    assign write_sync_o = write_sync_reg;
    assign posdet_o = posdet_reg;
    assign cmp_irq_o = cmp_irq_reg;
    assign irq_o = irq_reg;
endmodule : mpgpi_top

// file: sim/mpgpi_sva.sv
// Port checker for the position input control block.
// Assumes it is bound onto mpgpi_top and sees only its ports.
`timescale 1ns/1ps

module mpgpi_sva #(
    parameter int SENSORS = 3
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Register port
    input wire mpgpi_pkg::mpgpi_req_t req_i,
    input wire logic [7:0] rdata_o,
    // Bank, clock state and pins
    input wire mpgpi_pkg::mpgpi_bank_t bank_i,
    input wire logic clk_run_i,
    input wire logic pulse_gen_signal_i,
    input wire logic [SENSORS-1:0] sensor_in_i,
    // Events
    input wire logic write_sync_o,
    input wire logic posdet_o,
    input wire logic cmp_irq_o,
    input wire logic irq_o
);
    import mpgpi_pkg::*;
    // ======
    // Shadow bits and cycles since the last pin change
    logic ien_reg, mask_reg, pg_last_reg;
    logic [SENSORS-1:0] sn_last_reg;
    logic [7:0] pg_age_reg, sn_age_reg;
    wire logic pg_chg = pulse_gen_signal_i != pg_last_reg;
    wire logic sn_chg = sensor_in_i != sn_last_reg;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            {ien_reg, mask_reg, pg_last_reg} <= 3'h0;
            sn_last_reg <= '0;
            pg_age_reg <= 8'hFF;
            sn_age_reg <= 8'hFF;
        end else begin
            if (req_i.wr && req_i.addr == 4'h0) ien_reg <= req_i.wdata[4];
            if (req_i.wr && req_i.addr == 4'h3) mask_reg <= |req_i.wdata[2:0];
            pg_last_reg <= pulse_gen_signal_i;
            sn_last_reg <= sensor_in_i;
            pg_age_reg <= pg_chg ? 8'h00 : pg_age_reg + {7'h0, pg_age_reg != 8'hFF};
            sn_age_reg <= sn_chg ? 8'h00 : sn_age_reg + {7'h0, sn_age_reg != 8'hFF};
        end
    end
    // ======
    // Assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    a_read_idle_zero: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_rmw_flag_one: assert property (
        $past(req_i.rd && req_i.rmw && req_i.addr == 4'h0) |-> rdata_o[5])
        else $error("flag bit not one on rmw read");
    a_unmapped_read: assert property ($past(req_i.rd && req_i.addr > 4'h5) |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_wsync_cause: assert property (write_sync_o |-> pg_age_reg < 8'd8)
        else $error("write sync pulse without pulse gen edge");
    a_posdet_cause: assert property (posdet_o |-> sn_age_reg < 8'd48)
        else $error("position pulse without sensor edge");
    a_ien_gate: assert property (!ien_reg && !$past(ien_reg) |-> !cmp_irq_o)
        else $error("compare irq while disabled");
    a_cmp_rise_en: assert property ($rose(cmp_irq_o) |-> $past(ien_reg))
        else $error("compare irq rose without enable");
    a_mask_gate: assert property (!mask_reg && !$past(mask_reg) |-> !irq_o)
        else $error("irq while all masked");
    a_reset_quiet: assert property (
        $fell(reset_i) |-> !(write_sync_o | posdet_o | cmp_irq_o | irq_o) && rdata_o == 8'h00)
        else $error("outputs not quiet after reset");
    // Main scenarios
    c_cmp: cover property (cmp_irq_o);
    c_pos: cover property (posdet_o);
    c_irq: cover property (irq_o && write_sync_o == 1'b0);
endmodule : mpgpi_sva

bind mpgpi_top mpgpi_sva #(.SENSORS(SENSORS)) i_sva (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .req_i(req_i), .rdata_o(rdata_o), .bank_i(bank_i),
    .clk_run_i(clk_run_i), .pulse_gen_signal_i(pulse_gen_signal_i),
    .sensor_in_i(sensor_in_i), .write_sync_o(write_sync_o), .posdet_o(posdet_o),
    .cmp_irq_o(cmp_irq_o), .irq_o(irq_o));

// file: sim/mpgpi_sensor_model.sv
// Far side model: pulse generator signal and three sensor pins.
// Assumes drive is called just after a rising clock edge.
`timescale 1ns/1ps

module mpgpi_sensor_model (
    // Clock
    input wire logic ref_clk_i,
    // Pins
    output logic pulse_gen_signal_o,
    output logic [2:0] sensor_in_o
);
    // Pins rest low
    initial begin
        pulse_gen_signal_o = 1'b0;
        sensor_in_o = 3'h0;
    end
    // Set pin levels, then hold them a number of cycles
    task drive(input logic pg, input logic [2:0] sn, input int hold);
        pulse_gen_signal_o <= pg;
        sensor_in_o <= sn;
        repeat (hold) @(posedge ref_clk_i);
    endtask : drive
endmodule : mpgpi_sensor_model

// file: sim/tb_mpg_position_input_control.sv
// Bench for the position-detection input control block.
// Assumes mpgpi_top, the sensor model and the bound checker.
`timescale 1ns/1ps

module tb_mpg_position_input_control;
    import mpgpi_pkg::*;
    // ======
    // Stimulus, outputs and counters
    typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} mpgpi_row_t;
    mpgpi_row_t rows [5] = '{'{4'h0, 8'hFE, 8'hDE}, '{4'h1, 8'hA5, 8'hA5},
        '{4'h3, 8'h05, 8'h05}, '{4'h4, 8'h03, 8'h03}, '{4'h9, 8'hFF, 8'h00}};
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic clk_run_i = 1'b1;
    mpgpi_req_t req_i = '0;
    mpgpi_bank_t bank_i = '0;
    logic pg_pin, write_sync_o, posdet_o, cmp_irq_o, irq_o;
    logic [2:0] sn_pin;
    logic [7:0] rdata_o;
    logic [7:0] n_pos = 8'h00;
    logic [7:0] n_ws = 8'h00;
    int fail_count = 0;
    int samples_checked = 0;

    mpgpi_top i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req_i),
        .rdata_o(rdata_o), .bank_i(bank_i), .clk_run_i(clk_run_i),
        .pulse_gen_signal_i(pg_pin), .sensor_in_i(sn_pin), .write_sync_o(write_sync_o),
        .posdet_o(posdet_o), .cmp_irq_o(cmp_irq_o), .irq_o(irq_o));
    mpgpi_sensor_model i_far (.ref_clk_i(ref_clk_i), .pulse_gen_signal_o(pg_pin),
        .sensor_in_o(sn_pin));

    // Clock, 25 ns period
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // Count event pulses
    always @(posedge ref_clk_i) begin
        if (posdet_o === 1'b1) n_pos <= n_pos + 8'h01;
        if (write_sync_o === 1'b1) n_ws <= n_ws + 8'h01;
    end
    // ======
    // Tasks
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : cyc
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        req_i <= '{a, d, 1'b1, 1'b0, 1'b0};
        @(posedge ref_clk_i);
        req_i.wr <= 1'b0;
    endtask : wr
    task rdc(input logic [3:0] a, input logic m, input logic [7:0] e);
        @(posedge ref_clk_i);
        req_i <= '{a, 8'h00, 1'b0, 1'b1, m};
        @(posedge ref_clk_i);
        req_i.rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), rdata_o, e);
    endtask : rdc
    // Pulse pins high then low and let events settle
    task toggle(input logic pg, input logic [2:0] sn, input int hold);
        @(posedge ref_clk_i);
        n_pos <= 8'h00;
        n_ws <= 8'h00;
        i_far.drive(pg, sn, hold);
        i_far.drive(1'b0, 3'h0, hold);
        cyc(44);
    endtask : toggle
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // Watchdog
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        fail_count++;
        complete_run();
    end
    // ======
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        for (int a = 0; a < 5; a++) rdc(a[3:0], 1'b0, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rdc(rows[i].a, 1'b0, rows[i].e);
        end
        $display("test registers done");
        wr(4'h4, 8'h00);
        wr(4'h3, 8'h01);
        for (int c = 0; c < 8; c++) begin
            bank_i.index <= c[2:0] + 3'h1;
            wr(4'h0, {4'h1, c[2:0], 1'b1});
            bank_i.index <= c[2:0];
            cyc(3);
            chk("cmp irq", {7'h0, cmp_irq_o}, 8'h01);
            chk("irq", {7'h0, irq_o}, 8'h01);
            wr(4'h0, {4'h1, c[2:0], 1'b1});
            cyc(3);
            chk("cmp irq", {7'h0, cmp_irq_o}, 8'h00);
            rdc(4'h0, 1'b1, {4'h3, c[2:0], 1'b1});
            rdc(4'h0, 1'b0, {4'h1, c[2:0], 1'b1});
            wr(4'h2, 8'h01);
            cyc(2);
            chk("irq", {7'h0, irq_o}, 8'h00);
        end
        wr(4'h0, 8'h1E);
        cyc(4);
        chk("cmp irq", {7'h0, cmp_irq_o}, 8'h00);
        wr(4'h0, 8'h1F);
        cyc(3);
        chk("cmp irq", {7'h0, cmp_irq_o}, 8'h01);
        wr(4'h1, 8'h07);
        wr(4'h0, 8'h10);
        wr(4'h2, 8'h07);
        $display("test compare done");
        for (int p = 0; p < 4; p++) begin
            wr(4'h0, {p[1:0], 6'h00});
            toggle(1'b1, 3'h0, 3);
            chk("wsync", n_ws, {7'h0, p[0]} + {7'h0, p[1]});
            wr(4'h1, {p[1:0], 6'h01});
            toggle(1'b0, 3'h1, 3);
            chk("posdet", n_pos, {7'h0, p[0]} + {7'h0, p[1]});
        end
        for (int s = 0; s < 3; s++) begin
            wr(4'h1, 8'hC0 | (8'h01 << s));
            toggle(1'b0, 3'h1 << ((s + 1) % 3), 3);
            chk("posdet off", n_pos, 8'h00);
            toggle(1'b0, 3'h1 << s, 3);
            chk("posdet on", n_pos, 8'h02);
        end
        rdc(4'h2, 1'b0, 8'h06);
        wr(4'h3, 8'h06);
        cyc(2);
        chk("irq events", {7'h0, irq_o}, 8'h01);
        $display("test edges done");
        wr(4'h1, 8'h41);
        toggle(1'b0, 3'h1, 2);
        chk("bypass", n_pos, 8'h01);
        wr(4'h1, 8'h49);
        toggle(1'b0, 3'h1, 2);
        chk("glitch n2", n_pos, 8'h00);
        toggle(1'b0, 3'h1, 8);
        chk("pass n2", n_pos, 8'h01);
        wr(4'h4, 8'h03);
        toggle(1'b0, 3'h1, 20);
        chk("glitch n5", n_pos, 8'h00);
        toggle(1'b0, 3'h1, 40);
        chk("pass n5", n_pos, 8'h01);
        wr(4'h4, 8'h00);
        clk_run_i <= 1'b0;
        toggle(1'b0, 3'h1, 10);
        chk("stopped", n_pos, 8'h00);
        clk_run_i <= 1'b1;
        bank_i.bank_flag <= 1'b1;
        rdc(4'h5, 1'b0, 8'h08);
        $display("test filter done");
        // Reset again in mid-run: registers 0 to 4 back to zero
        reset_i <= 1'b1;
        cyc(3);
        reset_i <= 1'b0;
        for (int a = 0; a < 5; a++) rdc(a[3:0], 1'b0, 8'h00);
        chk("irq after reset", {7'h0, irq_o}, 8'h00);
        $display("test reset done");
        complete_run();
    end
endmodule : tb_mpg_position_input_control
